// file: bench/fcw_card_model.sv
`default_nettype none
module fcw_card_model
   import fcw_pkg::*;
(
   input wire logic [19:0] card_addr,
   input wire logic [15:0] card_data_out,
   input wire logic        card_we_n,
   input wire logic        card_ce1_n,
   input wire logic        card_ce2_n
);
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [19:0] addr;
      logic [15:0] data;
      logic        word;
   } fcw_pulse_type;
   fcw_pulse_type q[$];
   logic [47:0]   hist [8];
   logic [7:0]    prot = 8'h00;
   logic [7:0]    mem [logic [19:0]];
   logic [2:0]    chip;
   // Card has no clock: it latches on the falling strobe
   // Deselected card ignores the strobe
   always @(negedge card_we_n) if (!card_ce1_n || !card_ce2_n) begin
      q.push_back({card_addr, card_data_out, ~card_ce2_n});
      chip = {card_addr[19:18], card_addr[0] & card_ce2_n};
      mem[{chip, card_addr[17:1]}] = card_data_out[7:0];
      if (!card_ce2_n) begin
         mem[{chip | 3'h1, card_addr[17:1]}] = card_data_out[15:8];
      end
      if (card_addr[17:1] == LOC_FIRST[17:1] ||
          card_addr[17:1] == LOC_SECOND[17:1]) begin
         hist[chip] = {hist[chip][39:0], card_data_out[7:0]};
      end
      if (hist[chip][23:0] == 24'hAA_55A0) begin
         prot[chip] = 1'b1;
      end
      if (hist[chip] == 48'hAA55_80AA_5520) begin
         prot[chip] = 1'b0;
      end
   end
endmodule : fcw_card_model
`default_nettype wire

// file: bench/fcw_host_assertions.sv
`default_nettype none
module fcw_host_assertions
   import fcw_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic        req_valid,
   input wire logic        req_ready,
   input wire logic        busy,
   input wire logic [19:0] card_addr,
   input wire logic [15:0] card_data_out,
   input wire logic        card_data_oe,
   input wire logic        card_we_n,
   input wire logic        card_ce1_n,
   input wire logic        card_ce2_n,
   input wire logic        card_oe_n,
   input wire logic        card_reg_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------
   // Load gap
   // ---------------
   localparam int GAP_MAX = LOAD_CYC;
   logic [CNT_W-1:0] gap_r;
   logic [CNT_W-1:0] gap_nxt;
   // Counts while idle between pulses; only judged at the next fall
   always_comb begin
      gap_nxt = (busy && card_we_n) ? gap_r + 1'b1 : '0;
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         gap_r <= '0;
      end else begin
         gap_r <= gap_nxt;
      end
   end
   // ---------------
   // Properties
   // ---------------
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   we_low_width_a: assert property (
      $fell(card_we_n) |-> (!card_we_n) [*5] ##1 card_we_n)
      else $error("write pulse width wrong");
   we_high_width_a: assert property (
      $rose(card_we_n) |-> card_we_n [*5])
      else $error("write pulse high time short");
   addr_stable_a: assert property (
      !card_we_n && !$past(card_we_n) |->
         $stable(card_addr) && $stable(card_data_out))
      else $error("address or data moved in pulse");
   addr_setup_a: assert property (
      $fell(card_we_n) |-> $stable(card_addr))
      else $error("address not set before pulse");
   no_read_a: assert property (
      !card_we_n |-> card_data_oe && card_oe_n && card_reg_n)
      else $error("bus not driven or read strobe low");
   byte_lane_a: assert property (
      !card_we_n |-> !card_ce1_n)
      else $error("low enable missing in write");
   word_lane_a: assert property (
      !card_we_n && !card_ce2_n |-> !card_addr[0])
      else $error("word write with odd address");
   load_gap_a: assert property (
      $fell(card_we_n) |-> gap_r < GAP_MAX)
      else $error("load gap too long");
   refuse_busy_a: assert property (
      busy |-> !req_ready)
      else $error("ready while busy");
   take_req_a: assert property (
      req_valid && req_ready |=> busy)
      else $error("request not taken");
   cover property ($fell(card_we_n) && !card_ce2_n);
   cover property ($fell(card_we_n) && card_ce2_n && card_addr[0]);
   cover property (req_valid && busy);
endmodule : fcw_host_assertions
bind fcw_host fcw_host_assertions u_fcw_host_assertions (
   .core_clk, .rst, .req_valid, .req_ready, .busy, .card_addr,
   .card_data_out, .card_data_oe, .card_we_n, .card_ce1_n,
   .card_ce2_n, .card_oe_n, .card_reg_n
);
`default_nettype wire

// file: bench/fcw_host_tb.sv
`default_nettype none
module fcw_host_tb
   import fcw_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic        req_valid = 1'b0;
   logic [1:0]  req_op = 2'h0;
   logic [2:0]  req_chip = 3'h0;
   logic        req_word = 1'b0;
   logic [9:0]  req_sector = 10'h000;
   logic [15:0] fill_data = 16'h0000;
   logic        req_ready, fill_req, busy, done, card_data_oe;
   logic        card_we_n, card_ce1_n, card_ce2_n, card_oe_n, card_reg_n;
   logic [7:0]  fill_index;
   logic [19:0] card_addr;
   logic [15:0] card_data_out;
   int          n_mismatch = 0;
   int          checked = 0;
   int          n_fill = 0;
   logic        saw_done = 1'b0;
   always #10 core_clk = ~core_clk;
   always @(negedge core_clk) fill_data <= {~fill_index, fill_index};
   // Fill strobes and done pulses stand one cycle, so count them here
   always @(posedge core_clk) begin
      if (rst) begin
         n_fill   <= 0;
         saw_done <= 1'b0;
      end else begin
         n_fill   <= n_fill + int'(fill_req);
         saw_done <= saw_done | done;
      end
   end
   fcw_host u_dut (.core_clk, .rst, .req_valid, .req_ready, .req_op,
      .req_chip, .req_word, .req_sector, .fill_index, .fill_req,
      .fill_data, .busy, .done, .card_addr, .card_data_out,
      .card_data_oe, .card_we_n, .card_ce1_n, .card_ce2_n, .card_oe_n,
      .card_reg_n);
   fcw_card_model u_card (.card_addr, .card_data_out, .card_we_n,
      .card_ce1_n, .card_ce2_n);
   task automatic results();
      if (n_mismatch == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : results
   task automatic chk(string w, logic [19:0] exp, logic [19:0] got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s exp %h got %h", w, exp, got);
      end
   endtask : chk
   task automatic reset_card();
      @(negedge core_clk);
      rst = 1'b1;
      repeat (3) @(negedge core_clk);
      rst = 1'b0;
      u_card.q.delete();
   endtask : reset_card
   // Valid stays up for 20 cycles, most of them while busy, so every request also probes refusal
   task automatic start(logic [1:0] op, logic [2:0] c, logic w,
                        logic [9:0] s);
      @(negedge core_clk);
      {req_valid, req_op, req_chip} = {1'b1, op, c};
      {req_word, req_sector} = {w, s};
      repeat (20) @(negedge core_clk);
      req_valid = 1'b0;
   endtask : start
   task automatic collect(int n);
      for (int i = 0; i < n * 40 + 200 && u_card.q.size() < n; i++) begin
         @(negedge core_clk);
      end
      repeat (100) @(negedge core_clk);
      chk("busy", 20'h0_0001, {19'h0, busy});
      chk("done", 20'h0_0000, {19'h0, saw_done});
      if (u_card.q.size() != n) begin
         n_mismatch++;
         $display("CHECK FAILED pulses exp %0d got %0d", n, u_card.q.size());
         results();
      end
   endtask : collect
   task automatic cmds(logic [2:0] c, logic [47:0] seq, int n);
      logic [7:0]  b;
      logic [7:0]  g;
      logic [19:0] e;
      for (int k = 0; k < n; k++) begin
         b = seq[47 - 8 * k -: 8];
         g = u_card.q[k].data[7:0];
         e = {c[2:1], (b == CMD_SECOND) ? LOC_SECOND[17:1] :
             LOC_FIRST[17:1], c[0]};
         chk("cmd_addr", e, u_card.q[k].addr);
         chk("cmd_data", {12'h000, b}, {12'h000, g});
      end
   endtask : cmds
   task automatic loads(int b, int n, logic [2:0] c, logic w, logic [9:0] s);
      logic [19:0] a;
      logic [15:0] d;
      logic [19:0] x;
      for (int k = 0; k < n; k++) begin
         a = u_card.q[b + k].addr;
         d = u_card.q[b + k].data;
         x = w ? {4'h0, ~k[7:0], k[7:0]} : {12'h000, k[7:0]};
         chk("sector", {8'h00, c[2:1], s}, {8'h00, a[19:8]});
         chk("lane", {19'h0, k[0] & ~w}, {19'h0, a[0]});
         chk("word", {19'h0, w}, {19'h0, u_card.q[b + k].word});
         chk("data", x, w ? {4'h0, d} : {12'h000, d[7:0]});
      end
      chk("fills", n, n_fill);
   endtask : loads
   task automatic sc_protect_write();
      start(FCW_OP_PROTECT, 3'h5, 1'b0, 10'h3A5);
      collect(259);
      cmds(3'h5, 48'hAA55_A000_0000, 3);
      loads(3, 256, 3'h5, 1'b0, 10'h3A5);
      chk("protect", 20'h0_0020, {12'h000, u_card.prot});
      reset_card();
   endtask : sc_protect_write
   task automatic sc_unprotect_all();
      for (int c = 0; c < 8; c++) begin
         start(FCW_OP_UNPROT, c[2:0], 1'b0, 10'h000);
         collect(6);
         cmds(c[2:0], 48'hAA55_80AA_5520, 6);
         reset_card();
      end
      chk("unprotect", 20'h0_0000, {12'h000, u_card.prot});
   endtask : sc_unprotect_all
   task automatic sc_writes();
      start(FCW_OP_WRITE, 3'h6, 1'b1, 10'h001);
      collect(128);
      loads(0, 128, 3'h6, 1'b1, 10'h001);
      reset_card();
      start(FCW_OP_WRITE, 3'h0, 1'b0, 10'h3FF);
      collect(256);
      loads(0, 256, 3'h0, 1'b0, 10'h3FF);
      reset_card();
   endtask : sc_writes
   initial begin
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      rst = 1'b0;
      sc_protect_write();
      sc_unprotect_all();
      sc_writes();
      results();
   end
endmodule : fcw_host_tb
`default_nettype wire

// file: common/fcw_pkg.sv
`default_nettype none
package fcw_pkg;
   // ----------------------------------------
   // Card geometry
   // ----------------------------------------
   localparam int ADDR_W        = 20;
   localparam int DATA_W        = 16;
   localparam int SECTOR_W      = 10;
   localparam int CHIP_W        = 3;
   localparam int BYTE_COUNT    = 256;
   localparam int BYTE_IDX_W    = 8;
   localparam int SECTOR_LSB    = 8;
   localparam int PAIR_LSB      = 18;
   // ----------------------------------------
   // Command bytes and locations
   // ----------------------------------------
   localparam logic [7:0]  CMD_FIRST    = 8'hAA;
   localparam logic [7:0]  CMD_SECOND   = 8'h55;
   localparam logic [7:0]  CMD_PROTECT  = 8'hA0;
   localparam logic [7:0]  CMD_ERASE    = 8'h80;
   localparam logic [7:0]  CMD_UNPROT   = 8'h20;
   localparam logic [17:0] LOC_FIRST    = 18'h0_AAAA;
   localparam logic [17:0] LOC_SECOND   = 18'h0_5554;
   // ----------------------------------------
   // Timing at 50 MHz
   // ----------------------------------------
   localparam int CLK_NS        = 20;
   localparam int PULSE_NS      = 100;
   localparam int SETUP_NS      = 60;
   localparam int LOAD_US       = 150;
   localparam int RECOVER_MS    = 10;
   localparam int PULSE_CYC     = (PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int SETUP_CYC     = (SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int LOAD_CYC      = (LOAD_US * 1000) / CLK_NS;
   localparam int RECOVER_CYC   = (RECOVER_MS * 1000000) / CLK_NS;
   localparam int CNT_W         = 20;
   // ----------------------------------------
   // Operations and states
   // ----------------------------------------
   typedef enum logic [1:0] {
      FCW_OP_WRITE   = 2'h0,
      FCW_OP_PROTECT = 2'h1,
      FCW_OP_UNPROT  = 2'h2
   } fcw_op_type;
   typedef enum logic [5:0] {
      FCW_IDLE  = 6'b00_0001,
      FCW_SETUP = 6'b00_0010,
      FCW_LOW   = 6'b00_0100,
      FCW_HIGH  = 6'b00_1000,
      FCW_NEXT  = 6'b01_0000,
      FCW_WAIT  = 6'b10_0000
   } fcw_state_type;
endpackage : fcw_pkg
`default_nettype wire

// file: common/fcw_strobe_if.sv
`default_nettype none
interface fcw_strobe_if;
   logic        go;
   logic        done;
   logic [19:0] addr;
   logic [15:0] data;
   modport ctl (output go, output addr, output data, input done);
   modport gen (input go, input addr, input data, output done);
endinterface : fcw_strobe_if
`default_nettype wire

// file: rtl/fcw_host.sv
`default_nettype none
// How it works
// - Top two address bits pick chip pair, held through whole write pulse.
// - Word loads: pair bits held; lowest bit ignored, both bytes written.
// - Sector number presented on middle address bits at every load falling edge; command pulses carry the command location.
// - Next load starts within the load window limit, else loading ends.
// - Host waits the write recovery interval before any read.
// - Protect-and-write: AA, 55, A0 to command locations, then sector bytes.
// - Each of eight chips addressed on its own command locations.
// - Unprotect: AA, 55, 80, AA, 55, 20 to the chip's command locations.
// - Program is select sector, load all bytes, then wait.
module fcw_host
   import fcw_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire logic [1:0]  req_op,
   input  wire logic [2:0]  req_chip,
   input  wire logic        req_word,
   input  wire logic [9:0]  req_sector,
   output logic [7:0]       fill_index,
   output logic             fill_req,
   input  wire logic [15:0] fill_data,
   output logic             busy,
   output logic             done,
   output logic [19:0]      card_addr,
   output logic [15:0]      card_data_out,
   output logic             card_data_oe,
   output logic             card_we_n,
   output logic             card_ce1_n,
   output logic             card_ce2_n,
   output logic             card_oe_n,
   output logic             card_reg_n
);
   // ----------------------------------------
   // Sequencer state
   // ----------------------------------------
   fcw_state_type st_r, st_nxt;
   fcw_op_type    op_r, op_nxt;
   logic [2:0]    chip_r, chip_nxt;
   logic          word_r, word_nxt;
   logic [9:0]    sec_r, sec_nxt;
   logic [2:0]    cmd_r, cmd_nxt;
   logic [8:0]    idx_r, idx_nxt;
   logic [CNT_W-1:0] wait_r, wait_nxt;
   logic          done_r, done_nxt;
   logic          go;
   logic [19:0]   go_addr;
   logic [15:0]   go_data;
   logic [7:0]    cmd_byte;
   logic          cmd_second;
   logic [2:0]    cmd_len;
   logic [8:0]    load_len;

   fcw_strobe_if  cyc ();

   fcw_strobe u_strobe (
      .core_clk      (core_clk),
      .rst           (rst),
      .cyc           (cyc),
      .card_addr     (card_addr),
      .card_data_out (card_data_out),
      .card_data_oe  (card_data_oe),
      .card_we_n     (card_we_n)
   );

   // ----------------------------------------
   // Command byte table
   // ----------------------------------------
   always_comb begin
      cmd_second = 1'b0;
      cmd_byte   = CMD_FIRST;
      case (cmd_r)
         3'd0: cmd_byte = CMD_FIRST;
         3'd1: begin
            cmd_byte   = CMD_SECOND;
            cmd_second = 1'b1;
         end
         3'd2: cmd_byte = (op_r == FCW_OP_UNPROT) ? CMD_ERASE : CMD_PROTECT;
         3'd3: cmd_byte = CMD_FIRST;
         3'd4: begin
            cmd_byte   = CMD_SECOND;
            cmd_second = 1'b1;
         end
         default: cmd_byte = CMD_UNPROT;
      endcase
      // Plain write sends no command bytes
      cmd_len = (op_r == FCW_OP_UNPROT) ? 3'd6 :
                (op_r == FCW_OP_PROTECT) ? 3'd3 : 3'd0;
      // Word loads cover two bytes each
      load_len = word_r ? 9'd128 : 9'd256;
   end

   // ----------------------------------------
   // Address and data of next pulse
   // ----------------------------------------
   always_comb begin
      if (cmd_r < cmd_len) begin
         // Chip pair on top bits, odd chip sets bit zero
         go_addr = {chip_r[2:1], (cmd_second ? LOC_SECOND : LOC_FIRST)}
                   | {19'h0_0000, chip_r[0]};
         // Odd chip byte rides the low lane too; address bit zero picks the chip
         go_data = {8'h00, cmd_byte};
      end else if (word_r) begin
         go_addr = {chip_r[2:1], sec_r, idx_r[6:0], 1'b0};
         go_data = fill_data;
      end else begin
         // Lowest index bit alternates the even and odd chip of the pair,
         // so all 256 byte positions of the sector are loaded once each
         go_addr = {chip_r[2:1], sec_r, idx_r[7:0]};
         go_data = {8'h00, fill_data[7:0]};
      end
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   always_comb begin
      st_nxt   = st_r;
      op_nxt   = op_r;
      chip_nxt = chip_r;
      word_nxt = word_r;
      sec_nxt  = sec_r;
      cmd_nxt  = cmd_r;
      idx_nxt  = idx_r;
      wait_nxt = wait_r;
      done_nxt = 1'b0;
      go       = 1'b0;
      case (st_r)
         FCW_IDLE: if (req_valid) begin
            op_nxt   = fcw_op_type'(req_op);
            chip_nxt = req_chip;
            word_nxt = req_word;
            sec_nxt  = req_sector;
            cmd_nxt  = 3'd0;
            idx_nxt  = 9'd0;
            st_nxt   = FCW_SETUP;
         end
         FCW_SETUP: begin
            go     = 1'b1;
            st_nxt = FCW_LOW;
         end
         FCW_LOW: if (cyc.done) begin
            // Whole loop per pulse stays far below the load window
            if (cmd_r < cmd_len) begin
               cmd_nxt = cmd_r + 3'd1;
            end else begin
               idx_nxt = idx_r + 9'd1;
            end
            st_nxt = FCW_NEXT;
         end
         FCW_NEXT: begin
            if (op_r == FCW_OP_UNPROT && cmd_r >= cmd_len) begin
               wait_nxt = CNT_W'(RECOVER_CYC);
               st_nxt   = FCW_WAIT;
            end else if (cmd_r < cmd_len || idx_r < load_len) begin
               st_nxt = FCW_SETUP;
            end else begin
               // Silence past the window starts programming
               wait_nxt = CNT_W'(RECOVER_CYC);
               st_nxt   = FCW_WAIT;
            end
         end
         FCW_WAIT: if (wait_r <= CNT_W'(1)) begin
            done_nxt = 1'b1;
            st_nxt   = FCW_IDLE;
         end else begin
            wait_nxt = wait_r - CNT_W'(1);
         end
         default: st_nxt = FCW_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_r   <= FCW_IDLE;
         op_r   <= FCW_OP_WRITE;
         chip_r <= 3'd0;
         word_r <= 1'b0;
         sec_r  <= 10'h000;
         cmd_r  <= 3'd0;
         idx_r  <= 9'd0;
         wait_r <= '0;
         done_r <= 1'b0;
      end else begin
         st_r   <= st_nxt;
         op_r   <= op_nxt;
         chip_r <= chip_nxt;
         word_r <= word_nxt;
         sec_r  <= sec_nxt;
         cmd_r  <= cmd_nxt;
         idx_r  <= idx_nxt;
         wait_r <= wait_nxt;
         done_r <= done_nxt;
      end
   end

   assign cyc.go    = go;
   assign cyc.addr  = go_addr;
   assign cyc.data  = go_data;
   assign req_ready = (st_r == FCW_IDLE);
   assign busy      = (st_r != FCW_IDLE);
   assign done      = done_r;
   assign fill_index = idx_r[7:0];
   assign fill_req  = (st_r == FCW_SETUP) && (cmd_r >= cmd_len);
   // ----------------------------------------
   // Card controls
   // ----------------------------------------
   // Both enables low for word-mode loads; odd byte in byte mode rides the low lane, address bit zero picks the chip
   assign card_ce1_n = ~busy;
   assign card_ce2_n = ~(busy && word_r && (cmd_r >= cmd_len));
   // Never reads, so the output enable stays high
   assign card_oe_n  = 1'b1;
   assign card_reg_n = 1'b1;
endmodule : fcw_host
`default_nettype wire

// file: rtl/fcw_strobe.sv
`default_nettype none
module fcw_strobe
   import fcw_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst,
   fcw_strobe_if.gen        cyc,
   output logic [19:0]      card_addr,
   output logic [15:0]      card_data_out,
   output logic             card_data_oe,
   output logic             card_we_n
);
   // ----------------------------------------
   // One write pulse: setup, low, high
   // ----------------------------------------
   logic [1:0] ph_r, ph_nxt;
   logic [2:0] cnt_r, cnt_nxt;
   logic [19:0] a_r, a_nxt;
   logic [15:0] d_r, d_nxt;
   logic        we_r, we_nxt;

   always_comb begin
      ph_nxt  = ph_r;
      cnt_nxt = cnt_r;
      a_nxt   = a_r;
      d_nxt   = d_r;
      we_nxt  = we_r;
      cyc.done = 1'b0;
      case (ph_r)
         2'd0: if (cyc.go) begin
            // Address and data settle before the falling edge
            a_nxt   = cyc.addr;
            d_nxt   = cyc.data;
            cnt_nxt = 3'(SETUP_CYC);
            ph_nxt  = 2'd1;
         end
         2'd1: if (cnt_r <= 3'd1) begin
            we_nxt  = 1'b0;
            cnt_nxt = 3'(PULSE_CYC);
            ph_nxt  = 2'd2;
         end else begin
            cnt_nxt = cnt_r - 3'd1;
         end
         2'd2: if (cnt_r <= 3'd1) begin
            we_nxt  = 1'b1;
            cnt_nxt = 3'(PULSE_CYC);
            ph_nxt  = 2'd3;
         end else begin
            cnt_nxt = cnt_r - 3'd1;
         end
         default: if (cnt_r <= 3'd1) begin
            // Address held through the high time too
            cyc.done = 1'b1;
            ph_nxt   = 2'd0;
         end else begin
            cnt_nxt = cnt_r - 3'd1;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ph_r  <= 2'd0;
         cnt_r <= 3'd0;
         a_r   <= 20'h0_0000;
         d_r   <= 16'h0000;
         we_r  <= 1'b1;
      end else begin
         ph_r  <= ph_nxt;
         cnt_r <= cnt_nxt;
         a_r   <= a_nxt;
         d_r   <= d_nxt;
         we_r  <= we_nxt;
      end
   end

   assign card_addr     = a_r;
   assign card_data_out = d_r;
   assign card_data_oe  = (ph_r != 2'd0);
   assign card_we_n     = we_r;
endmodule : fcw_strobe
`default_nettype wire
